// File: src/ccsh_top.sv
// common status command interpreter with event reporting and apb registers
// Operation
// (R1) step jump moves execution cursor to argument
// (R2) star and vendor forms act identically
// (R3) clear status empties queue and events
// (R4) device clear restores default state
// (R5) enable mask 0-255 stored and queryable
// (R6) enabled events ORed into status bit 5
// (R7) enable mask survives reset, cleared at power
// (R8) event query returns register then clears it
// (R9) event register records the seven conditions
// (R10) go-to-local releases front panel lock
// (R11) local lockout locks front panel
// (R12) identity gives four fields in order
// (R13) operation complete sets bit 0 when idle
// (R14) summary bit follows register and mask
`timescale 1ns/10ps
module ccsh_top
  import ccsh_pkg::*;
#(
  parameter int STEP_W = 8, // cursor width
  parameter int MAX_STEP = 25, // highest valid step number
  parameter int ERRQ_W = 4 // error queue depth counter width
) (
  input wire logic core_clk_i, // system clock, 25 MHz
  input wire logic rst_n_i, // power-on reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb enable
  input wire logic pwrite_i, // apb direction
  input wire logic [ADDR_W-1:0] paddr_i, // apb byte address
  input wire logic [DATA_W-1:0] pwdata_i, // apb write data
  output logic [DATA_W-1:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error
  input wire logic ops_pending_i, // overlapped operations still running
  input wire logic dev_err_i, // device dependent error pulse
  input wire logic req_ctrl_i, // request control pulse
  input wire logic instr_pending_i, // sequence waits for user input
  input wire logic [7:0] ques_set_i, // questionable event pulses
  input wire logic [7:0] oper_set_i, // operation event pulses
  output logic [STEP_W-1:0] step_cursor_o, // sequence cursor
  output logic step_jump_o, // cursor moved, one cycle
  output logic panel_lock_o, // front panel locked out
  output logic dev_clear_o, // return to default state, one cycle
  output logic summary_o, // event summary bit
  output logic irq_o // level interrupt
);
  if (STEP_W < 1 || STEP_W > CMD_ARG_W || MAX_STEP >= 2**STEP_W
      || ERRQ_W < 1 || ERRQ_W > 4)
  begin : g_chk
    $error("ccsh_top: step or error queue parameters out of range");
  end

  localparam logic [15:0] MAX_STEP_L = 16'(MAX_STEP);
  localparam logic [ERRQ_W-1:0] ERRQ_FULL = '1;

  ccsh_state_t state_q; // command engine state
  logic [7:0] op_q; // latched opcode
  logic [15:0] arg_q; // latched argument
  ccsh_act_t act; // decoded action of the latched opcode
  logic exec; // engine executes this cycle
  logic acc; // apb access completes this cycle
  logic is_wr; // completing write
  logic is_rd; // completing read
  logic rd_err; // setup of an access that will be refused
  logic cmd_wr; // accepted command write
  logic [DATA_W-1:0] rdata_d; // read mux
  logic [ESR_W-1:0] esr_q; // standard event register
  logic [ESR_W-1:0] esr_set; // events this cycle
  logic [7:0] ese_q; // event enable mask
  logic [7:0] ques_q; // questionable events
  logic [7:0] oper_q; // operation events
  logic [DATA_W-1:0] resp_q; // query answer
  logic resp_vld_q; // answer waiting
  logic [DATA_W-1:0] rom_data; // identity field
  logic opc_pend_q; // operation complete armed
  logic pon_q; // first cycle after power-on
  logic [ERRQ_W-1:0] err_cnt_q; // error queue fill
  logic [IRQ_W-1:0] irq_stat_q; // sticky interrupt sources
  logic [IRQ_W-1:0] irq_mask_q; // interrupt enables
  logic [IRQ_W-1:0] irq_set; // interrupt events
  logic ev_cme; // unknown command
  logic ev_exe; // argument refused
  logic ev_qye; // answer read when none waits
  logic opc_done; // operation complete fires
  logic jump_ok; // jump argument accepted
  logic cls; // clear status this cycle
  logic [7:0] stb; // status byte

  // apb handshake terms
  assign acc = psel_i & penable_i & pready_o;
  assign is_wr = acc & pwrite_i;
  assign is_rd = acc & ~pwrite_i;
  assign cmd_wr = is_wr & (paddr_i == OFF_CMD) & ~pslverr_o;

  // engine terms
  assign exec = (state_q == ST_EXEC);
  assign act = ccsh_act_of(op_q); // R2
  assign cls = exec & (act == ACT_CLS);
  assign jump_ok = (arg_q <= MAX_STEP_L) & ~instr_pending_i;
  assign ev_cme = exec & (act == ACT_BAD);
  // range breaches and blocked jumps are execution errors
  assign ev_exe = exec & (((act == ACT_ESE_W) & (arg_q > ESE_MAX))
                  | ((act == ACT_JUMP) & ~jump_ok)
                  | ((act == ACT_IDN) & (arg_q > ID_LAST))); // R5
  assign ev_qye = is_rd & (paddr_i == OFF_RESP) & ~resp_vld_q;
  assign opc_done = opc_pend_q & ~ops_pending_i; // R13

  // conditions recorded by the event register
  always_comb
  begin
    esr_set = '0;
    esr_set[ESR_OPC] = opc_done; // R9
    esr_set[ESR_RQC] = req_ctrl_i;
    esr_set[ESR_QYE] = ev_qye;
    esr_set[ESR_DDE] = dev_err_i;
    esr_set[ESR_EXE] = ev_exe;
    esr_set[ESR_CME] = ev_cme;
    esr_set[ESR_PON] = pon_q;
  end

  // status byte assembled from the summaries
  always_comb
  begin
    stb = '0;
    stb[STB_EAV] = (err_cnt_q != '0);
    stb[STB_QUES] = |ques_q;
    stb[STB_MAV] = resp_vld_q;
    stb[STB_ESB] = summary_o; // R6
    stb[STB_OPER] = |oper_q;
  end

  // read mux, sampled when ready goes high
  always_comb
  begin
    rdata_d = '0;
    case (paddr_i)
      OFF_RESP: rdata_d = resp_q;
      OFF_STAT:
      begin
        rdata_d[7:0] = stb;
        rdata_d[STAT_LOCK] = panel_lock_o;
        rdata_d[STAT_BUSY] = ~(state_q == ST_IDLE);
        rdata_d[STAT_OPCP] = opc_pend_q;
        rdata_d[STAT_ERR_LSB +: ERRQ_W] = err_cnt_q;
        rdata_d[STAT_CUR_LSB +: STEP_W] = step_cursor_o;
      end
      OFF_ESRV: rdata_d[ESR_W-1:0] = esr_q;
      OFF_ESE: rdata_d[7:0] = ese_q; // R5
      OFF_IRQS: rdata_d[IRQ_W-1:0] = irq_stat_q;
      OFF_IRQM: rdata_d[IRQ_W-1:0] = irq_mask_q;
      OFF_QUES: rdata_d[7:0] = ques_q;
      OFF_OPER: rdata_d[7:0] = oper_q;
      default: rdata_d = '0; // command word reads as zero
    endcase
  end

  // refused: unmapped address, or command while the engine is busy
  assign rd_err = ~((paddr_i == OFF_CMD) | (paddr_i == OFF_RESP)
                  | (paddr_i == OFF_STAT) | (paddr_i == OFF_ESRV)
                  | (paddr_i == OFF_ESE) | (paddr_i == OFF_IRQS)
                  | (paddr_i == OFF_IRQM) | (paddr_i == OFF_QUES)
                  | (paddr_i == OFF_OPER))
                  | (pwrite_i & (paddr_i == OFF_CMD)
                     & ~(state_q == ST_IDLE));

  // apb answer one cycle into the access phase
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end
    else if (psel_i & penable_i & ~pready_o)
    begin
      pready_o <= 1'b1;
      pslverr_o <= rd_err;
      prdata_o <= rdata_d;
    end
    else
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // command engine: capture, execute, wait on the identity store
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= ST_IDLE;
      op_q <= '0;
      arg_q <= '0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          if (cmd_wr)
          begin
            op_q <= pwdata_i[CMD_OP_LSB +: CMD_OP_W];
            arg_q <= pwdata_i[CMD_ARG_LSB +: CMD_ARG_W];
            state_q <= ST_EXEC;
          end
        ST_EXEC:
          if (act == ACT_IDN && !ev_exe)
            state_q <= ST_ROM; // store answers one cycle later
          else
            state_q <= ST_IDLE;
        ST_ROM: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // identity field store, indexed by the argument
  ccsh_id_rom u_id_rom (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(arg_q[ID_AW-1:0]),
    .data_o(rom_data)
  );

  // standard event register, cleared by status clear or by its query
  ccsh_evt_reg #(.W(ESR_W)) u_esr (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(esr_set),
    .clr_i(cls | (exec & (act == ACT_ESR_Q))), // R3 R8
    .evt_o(esr_q)
  );

  // questionable and operation registers, cleared by status clear
  ccsh_evt_reg #(.W(8)) u_ques (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(ques_set_i),
    .clr_i(cls), // R3
    .evt_o(ques_q)
  );

  ccsh_evt_reg #(.W(8)) u_oper (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .set_i(oper_set_i),
    .clr_i(cls), // R3
    .evt_o(oper_q)
  );

  // power-on flag raises the power-on event once
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      pon_q <= 1'b1;
    else
      pon_q <= 1'b0;
  end

  // enable mask: only power-on clears it, reset commands leave it
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      ese_q <= '0; // R7
    else if (exec & (act == ACT_ESE_W) & ~ev_exe)
      ese_q <= arg_q[7:0]; // R5
  end

  // summary recomputed every cycle from register and mask
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      summary_o <= 1'b0;
    else
      summary_o <= |(esr_q & ese_q); // R6 R14
  end

  // query answers; a read of the answer word consumes it
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      resp_q <= '0;
      resp_vld_q <= 1'b0;
    end
    else if (exec & (act == ACT_ESE_Q))
    begin
      resp_q <= {24'h000000, ese_q};
      resp_vld_q <= 1'b1;
    end
    else if (exec & (act == ACT_ESR_Q))
    begin
      resp_q <= {24'h000000, esr_q}; // R8
      resp_vld_q <= 1'b1;
    end
    else if (state_q == ST_ROM)
    begin
      resp_q <= rom_data; // R12
      resp_vld_q <= 1'b1;
    end
    else if ((exec & (act == ACT_DCL)) | (is_rd & (paddr_i == OFF_RESP)))
      resp_vld_q <= 1'b0;
  end

  // front panel lock
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      panel_lock_o <= 1'b0;
    else if (exec & (act == ACT_LLO))
      panel_lock_o <= 1'b1; // R11
    else if (exec & ((act == ACT_GTL) | (act == ACT_DCL) | (act == ACT_RST)))
      panel_lock_o <= 1'b0; // R10 R4
  end

  // sequence cursor and jump pulse
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      step_cursor_o <= '0;
      step_jump_o <= 1'b0;
    end
    else
    begin
      step_jump_o <= exec & (act == ACT_JUMP) & jump_ok;
      if (exec & (act == ACT_JUMP) & jump_ok)
        step_cursor_o <= arg_q[STEP_W-1:0]; // R1
      else if (exec & ((act == ACT_DCL) | (act == ACT_RST)))
        step_cursor_o <= '0; // R4
    end
  end

  // device clear pulse and operation complete arming
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      dev_clear_o <= 1'b0;
      opc_pend_q <= 1'b0;
    end
    else
    begin
      dev_clear_o <= exec & (act == ACT_DCL); // R4
      if (exec & (act == ACT_OPC))
        opc_pend_q <= 1'b1;
      else if (opc_done | (exec & ((act == ACT_DCL) | (act == ACT_RST))))
        opc_pend_q <= 1'b0; // R13
    end
  end

  // error queue fill, saturating; status clear empties it
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      err_cnt_q <= '0;
    else if (cls)
      err_cnt_q <= '0; // R3
    else if ((ev_cme | ev_exe | ev_qye) & (err_cnt_q != ERRQ_FULL))
      err_cnt_q <= err_cnt_q + 1'b1;
  end

  // interrupt status, mask and output; a new event beats a clear
  assign irq_set = {opc_done, step_jump_o, ev_cme | ev_exe, state_q == ST_ROM
                    || (exec & ((act == ACT_ESE_Q) | (act == ACT_ESR_Q)))};
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      if (is_wr & (paddr_i == OFF_IRQS))
        irq_stat_q <= (irq_stat_q & ~pwdata_i[IRQ_W-1:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
      if (is_wr & (paddr_i == OFF_IRQM))
        irq_mask_q <= pwdata_i[IRQ_W-1:0];
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  jump_cursor_a: assert property ( // R1
    exec && act == ACT_JUMP && jump_ok |=>
      step_cursor_o == $past(arg_q[STEP_W-1:0]) && step_jump_o)
    else $error("cursor did not follow jump");
  alias_same_a: assert property ( // R2
    exec |-> act == ccsh_act_of({~op_q[VEND_BIT], op_q[6:0]}))
    else $error("star and vendor forms decode apart");
  cls_clear_a: assert property ( // R3
    cls |=> err_cnt_q == '0 && ques_q == $past(ques_set_i))
    else $error("clear status left state behind");
  dcl_default_a: assert property ( // R4
    exec && act == ACT_DCL |=> dev_clear_o && !panel_lock_o
      && step_cursor_o == '0)
    else $error("device clear left state behind");
  ese_store_a: assert property ( // R5
    exec && act == ACT_ESE_W && arg_q <= ESE_MAX |=>
      ese_q == $past(arg_q[7:0]) ##1 $stable(ese_q))
    else $error("enable mask not stored");
  summary_bit_a: assert property ( // R6 R14
    ##1 summary_o == $past(|(esr_q & ese_q)))
    else $error("summary bit stale");
  ese_keep_a: assert property ( // R7
    exec && (act == ACT_RST || act == ACT_DCL) |=> $stable(ese_q))
    else $error("enable mask lost on reset command");
  esr_read_a: assert property ( // R8
    exec && act == ACT_ESR_Q |=> resp_q[7:0] == $past(esr_q)
      && esr_q == $past(esr_set))
    else $error("event query did not read and clear");
  cme_flag_a: assert property ( // R9
    ev_cme |=> esr_q[ESR_CME] && !$past(state_q == ST_IDLE))
    else $error("command error not recorded");
  lock_a: assert property ( // R10 R11
    exec && (act == ACT_LLO || act == ACT_GTL) |=>
      panel_lock_o == $past(act == ACT_LLO))
    else $error("panel lock wrong");
  idn_a: assert property ( // R12
    exec && act == ACT_IDN && !ev_exe |=> ##1 resp_vld_q
      && resp_q == $past(rom_data))
    else $error("identity field not answered");
  opc_a: assert property ( // R13
    opc_pend_q && !ops_pending_i |=> esr_q[ESR_OPC] && !opc_pend_q)
    else $error("operation complete not flagged");

  jump_c: cover property (step_jump_o);
  esr_query_c: cover property (exec && act == ACT_ESR_Q && esr_q != '0);
  idn_c: cover property (state_q == ST_ROM);
  lock_c: cover property (panel_lock_o ##[1:20] !panel_lock_o);
endmodule

// File: src/ccsh_pkg.sv
// shared constants, types and decode for the common status command handler
package ccsh_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;  // command word, write starts it
  localparam logic [7:0] OFF_RESP = 8'h04; // last query answer
  localparam logic [7:0] OFF_STAT = 8'h08; // status byte and block state
  localparam logic [7:0] OFF_ESRV = 8'h0C; // event register, no clear
  localparam logic [7:0] OFF_ESE = 8'h10;  // event enable mask view
  localparam logic [7:0] OFF_IRQS = 8'h14; // interrupt status, write 1 clear
  localparam logic [7:0] OFF_IRQM = 8'h18; // interrupt mask
  localparam logic [7:0] OFF_QUES = 8'h1C; // questionable event register
  localparam logic [7:0] OFF_OPER = 8'h20; // operation event register

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 8;
  localparam int CMD_ARG_LSB = 8;
  localparam int CMD_ARG_W = 16;
  localparam int VEND_BIT = 7; // set: vendor spelling of the same command

  // command codes, low seven bits of the opcode
  localparam logic [6:0] CODE_CLS = 7'h01;
  localparam logic [6:0] CODE_DCL = 7'h02;
  localparam logic [6:0] CODE_ESE_W = 7'h03;
  localparam logic [6:0] CODE_ESE_Q = 7'h04;
  localparam logic [6:0] CODE_ESR_Q = 7'h05;
  localparam logic [6:0] CODE_GTL = 7'h06;
  localparam logic [6:0] CODE_IDN = 7'h07;
  localparam logic [6:0] CODE_LLO = 7'h08;
  localparam logic [6:0] CODE_OPC = 7'h09;
  localparam logic [6:0] CODE_RST = 7'h0A;
  localparam logic [6:0] CODE_JUMP = 7'h0B;

  // event register bits
  localparam int ESR_W = 8;
  localparam int ESR_OPC = 0;
  localparam int ESR_RQC = 1;
  localparam int ESR_QYE = 2;
  localparam int ESR_DDE = 3;
  localparam int ESR_EXE = 4;
  localparam int ESR_CME = 5;
  localparam int ESR_PON = 7;
  localparam logic [15:0] ESE_MAX = 16'h00FF;

  // status byte bits
  localparam int STB_EAV = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_OPER = 7;

  // status register layout above the status byte
  localparam int STAT_LOCK = 8;
  localparam int STAT_BUSY = 9;
  localparam int STAT_OPCP = 10;
  localparam int STAT_ERR_LSB = 12;
  localparam int STAT_CUR_LSB = 16;

  // interrupt sources
  localparam int IRQ_W = 4;
  localparam int IRQ_RESP = 0;
  localparam int IRQ_CERR = 1;
  localparam int IRQ_JUMP = 2;
  localparam int IRQ_OPC = 3;

  // identity fields
  localparam int ID_AW = 2;
  localparam logic [15:0] ID_LAST = 16'h0003;

  typedef enum logic [3:0] {
    ACT_CLS, ACT_DCL, ACT_ESE_W, ACT_ESE_Q, ACT_ESR_Q, ACT_GTL,
    ACT_IDN, ACT_LLO, ACT_OPC, ACT_RST, ACT_JUMP, ACT_BAD
  } ccsh_act_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_ROM = 3'b100
  } ccsh_state_t;

  // star and vendor spellings differ only in the vendor bit
  function automatic ccsh_act_t ccsh_act_of(input logic [7:0] op);
    case (op[6:0]) // R2
      CODE_CLS: return ACT_CLS;
      CODE_DCL: return ACT_DCL;
      CODE_ESE_W: return ACT_ESE_W;
      CODE_ESE_Q: return ACT_ESE_Q;
      CODE_ESR_Q: return ACT_ESR_Q;
      CODE_GTL: return ACT_GTL;
      CODE_IDN: return ACT_IDN;
      CODE_LLO: return ACT_LLO;
      CODE_OPC: return ACT_OPC;
      CODE_RST: return ACT_RST;
      CODE_JUMP: return ACT_JUMP;
      default: return ACT_BAD;
    endcase
  endfunction

endpackage

// File: src/ccsh_evt_reg.sv
// sticky event register, a new event wins over a clear in the same cycle
`timescale 1ns/10ps
module ccsh_evt_reg #(
  parameter int W = 8 // register width
) (
  input wire logic core_clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic [W-1:0] set_i, // event pulses
  input wire logic clr_i, // clear all bits
  output logic [W-1:0] evt_o // latched events
);
  if (W < 1)
  begin : g_chk
    $error("ccsh_evt_reg: width must be at least one");
  end

  // set wins over clear so an event on the clear cycle survives
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      evt_o <= '0;
    else if (clr_i)
      evt_o <= set_i;
    else
      evt_o <= evt_o | set_i;
  end
endmodule

// File: src/ccsh_id_rom.sv
// identity field store with registered read data
`timescale 1ns/10ps
module ccsh_id_rom
  import ccsh_pkg::*;
#(
  parameter logic [31:0] MFR_CODE = 32'h4E455554, // arbitrary value
  parameter logic [31:0] MODEL_CODE = 32'h00000A01, // arbitrary value
  parameter logic [31:0] SERIAL_NUM = 32'h00001234, // arbitrary value
  parameter logic [31:0] FW_REV = 32'h00010000 // arbitrary value
) (
  input wire logic core_clk_i, // system clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic [ID_AW-1:0] addr_i, // field index
  output logic [DATA_W-1:0] data_o // field word, one cycle later
);
  logic [DATA_W-1:0] rom [2**ID_AW]; // fields in answer order

  // fields in answer order: maker, model, serial, firmware
  assign rom[0] = MFR_CODE; // R12
  assign rom[1] = MODEL_CODE;
  assign rom[2] = SERIAL_NUM;
  assign rom[3] = FW_REV;

  // registered read port
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      data_o <= '0;
    else
      data_o <= rom[addr_i];
  end
endmodule

// File: test/ccsh_host.sv
// host model: apb master standing in for the remote controller
`timescale 1ns/10ps
module ccsh_host
  import ccsh_pkg::*;
(
  input wire logic core_clk_i, // clock
  input wire logic [DATA_W-1:0] prdata_i, // read data
  input wire logic pready_i, // ready
  input wire logic pslverr_i, // error
  output logic psel_o = 1'b0, // select
  output logic penable_o = 1'b0, // enable
  output logic pwrite_o = 1'b0, // direction
  output logic [ADDR_W-1:0] paddr_o = 8'h00, // address
  output logic [DATA_W-1:0] pwdata_o = 32'h0 // write data
);
  // one transfer, held until ready; released address and write data show inverted
  // values so stale data is never mistaken for a live request
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] r,
    output logic e);
    @(posedge core_clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge core_clk_i);
    penable_o <= 1'b1;
    do
      @(posedge core_clk_i);
    while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule

// File: test/ccsh_tb.sv
// self-checking bench for the common status command handler
`timescale 1ns/10ps
module ccsh_tb;
  import ccsh_pkg::*;
  localparam int MAXS = 25; // highest step
  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, active low
  logic psel, pen, pwr, perr, prdy; // apb wires
  logic [7:0] pa; // apb address
  logic [31:0] pwd, prd, rs = 32'h79824B04; // data, lfsr state
  logic opsp = 1'b0, derr = 1'b0, rqc = 1'b0, ipend = 1'b0; // events
  logic [7:0] qs = 8'h00, os = 8'h00, cur; // event pulses, cursor
  logic jmp, lock, dcl, sum, irq; // block outputs
  int num_errors = 0, n_compared = 0, cyc = 0, n_dcl = 0, n_jmp = 0;
  always #20 clk = ~clk;
  ccsh_top #(.MAX_STEP(MAXS)) i_ccsh_top (.core_clk_i(clk),
    .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
    .pslverr_o(perr), .ops_pending_i(opsp), .dev_err_i(derr),
    .req_ctrl_i(rqc), .instr_pending_i(ipend), .ques_set_i(qs),
    .oper_set_i(os), .step_cursor_o(cur), .step_jump_o(jmp),
    .panel_lock_o(lock), .dev_clear_o(dcl), .summary_o(sum),
    .irq_o(irq));
  ccsh_host i_ccsh_host (.core_clk_i(clk), .prdata_i(prd),
    .pready_i(prdy), .pslverr_i(perr), .psel_o(psel), .penable_o(pen),
    .pwrite_o(pwr), .paddr_o(pa), .pwdata_o(pwd));
  // count one-cycle pulses; cut a hang short
  always @(posedge clk)
  begin
    n_dcl <= n_dcl + int'(dcl === 1'b1);
    n_jmp <= n_jmp + int'(jmp === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test;
    end
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic esb(input logic [7:0] r, input logic [7:0] m);
    return |(r & m);
  endfunction
  // event bit expected for each stimulus of the event loop
  function automatic logic [31:0] evx(input int k);
    case (k)
      0: return 32'h1 << ESR_DDE;
      1: return 32'h1 << ESR_RQC;
      2: return 32'h1 << ESR_CME;
      3: return 32'h1 << ESR_EXE;
      default: return 32'h1 << ESR_QYE;
    endcase
  endfunction
  // identity words in answer order (arbitrary values of the store)
  function automatic logic [31:0] idv(input int i);
    case (i)
      0: return 32'h4E455554;
      1: return 32'h00000A01;
      2: return 32'h00001234;
      default: return 32'h00010000;
    endcase
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    i_ccsh_host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    i_ccsh_host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    rd(a, r);
    chk(r, x);
  endtask
  // spelling picked at random: both forms must act alike
  task automatic cmd(input logic [6:0] c, input logic [15:0] g);
    rs = nxt(rs);
    wr(OFF_CMD, {8'h00, g, rs[0], c});
    repeat (3) @(posedge clk);
  endtask
  task automatic pulse(input logic [17:0] v);
    @(posedge clk);
    {derr, rqc, qs, os} <= v;
    @(posedge clk);
    {derr, rqc, qs, os} <= 18'h00000;
  endtask
  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin : main
    logic [31:0] r;
    logic e;
    logic [15:0] v;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc(OFF_ESRV, 32'h80);
    rc(OFF_ESE, 32'h0);
    i_ccsh_host.xfer(1'b0, 8'h40, 32'h0, r, e);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      rs = nxt(rs);
      v = (i < 2) ? 16'(i * 255) : {8'h00, rs[7:0]};
      cmd(CODE_ESE_W, v);
      rc(OFF_ESE, v);
      rd(OFF_STAT, r);
      chk(r[STB_ESB], esb(8'h80, v[7:0]));
      chk(sum, esb(8'h80, v[7:0]));
      cmd(CODE_ESE_Q, 16'h0);
      rc(OFF_RESP, v);
    end
    cmd(CODE_ESR_Q, 16'h0);
    rc(OFF_RESP, 32'h80);
    rc(OFF_ESRV, 32'h0);
    chk(sum, 1'b0);
    cmd(CODE_ESE_W, 16'h00FF);
    for (int k = 0; k < 5; k++)
    begin
      case (k)
        0: pulse(18'h20000);
        1: pulse(18'h10000);
        2: cmd(7'h7F, 16'h0);
        3: cmd(CODE_ESE_W, 16'd300);
        default: rd(OFF_RESP, r);
      endcase
      rc(OFF_ESRV, evx(k));
      chk(sum, 1'b1);
      cmd(CODE_ESR_Q, 16'h0);
      rd(OFF_RESP, r);
    end
    opsp <= 1'b1;
    cmd(CODE_OPC, 16'h0);
    rc(OFF_ESRV, 32'h0);
    opsp <= 1'b0;
    rc(OFF_ESRV, 32'h1);
    rs = nxt(rs);
    pulse({2'b00, rs[7:0] | 8'h01, rs[15:8] | 8'h80});
    cmd(7'h7F, 16'h0);
    rd(OFF_STAT, r);
    chk(r & 32'hAC, 32'hAC);
    cmd(CODE_CLS, 16'h0);
    rc(OFF_QUES, 32'h0);
    rc(OFF_OPER, 32'h0);
    rc(OFF_ESRV, 32'h0);
    rd(OFF_STAT, r);
    chk(r & 32'hF0FF, 32'h0);
    cmd(CODE_LLO, 16'h0);
    chk(lock, 1'b1);
    cmd(CODE_GTL, 16'h0);
    chk(lock, 1'b0);
    cmd(CODE_LLO, 16'h0);
    cmd(CODE_RST, 16'h0);
    chk(lock, 1'b0);
    rc(OFF_ESE, 32'hFF);
    wr(OFF_IRQS, 32'hF);
    wr(OFF_IRQM, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      rs = nxt(rs);
      v = (i == 0) ? 16'(MAXS) : 16'(rs[7:0] % (MAXS + 1));
      cmd(CODE_JUMP, v);
      chk(cur, v[7:0]);
      @(posedge clk);
      chk(irq, 1'b1);
      wr(OFF_IRQS, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
    end
    wr(OFF_IRQM, 32'h0);
    cmd(CODE_JUMP, 16'h3);
    @(posedge clk);
    chk(irq, 1'b0);
    rc(OFF_IRQS, 32'h4);
    cmd(CODE_JUMP, 16'(MAXS + 1));
    ipend <= 1'b1;
    cmd(CODE_JUMP, 16'h1);
    ipend <= 1'b0;
    chk({cur, 24'(n_jmp)}, {8'h03, 24'd5});
    cmd(CODE_LLO, 16'h0);
    cmd(CODE_DCL, 16'h0);
    @(posedge clk);
    chk({n_dcl[7:0], lock, cur}, {8'h01, 1'b0, 8'h00});
    for (int i = 0; i < 4; i++)
    begin
      cmd(CODE_IDN, 16'(i));
      rc(OFF_RESP, idv(i));
    end
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc(OFF_ESE, 32'h0);
    finish_test;
  end
endmodule
